/* File: design/crcbe_pkg.sv */
package crcbe_pkg;

  // ==========================================================
  // crc parameters
  localparam logic [15:0] CRCBE_POLY = 16'h1021;
  localparam logic [15:0] CRCBE_SEED_ZERO = 16'h0000;
  localparam logic [15:0] CRCBE_SEED_ONES = 16'hffff;
  localparam logic [15:0] CRCBE_RST_RESULT = 16'h0000;
  localparam int CRCBE_BLOCK_BYTES = 256;
  localparam int CRCBE_ADDR_W = 16;
  localparam int CRCBE_BLKCNT_W = 8;
  localparam logic [7:0] CRCBE_LAST_IN_BLOCK = 8'hff;
  // flash read latency in cycles, address to data
  localparam int CRCBE_FLASH_LAT = 1;
  // one 256-byte block plus pipeline must fit in this many cycles
  localparam int CRCBE_BLOCK_CYCLES_MAX = 270;

  // ==========================================================
  // walk states
  typedef enum logic [2:0] {
    CRCBE_IDLE = 3'b001,
    CRCBE_WALK = 3'b010,
    CRCBE_DRAIN = 3'b100
  } crcbe_state_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } crcbe_byte_s;

  typedef struct packed {
    crcbe_state_e state;
    logic [15:0] result;
    logic [CRCBE_ADDR_W-1:0] addr;
    logic [CRCBE_BLKCNT_W-1:0] blocks_left;
    logic rd_pend;
    logic last_pend;
    logic done;
    logic reverse;
  } crcbe_state_s;

endpackage : crcbe_pkg

/* File: design/crcbe_step.sv */
`timescale 1ns/1ps
module crcbe_step
  import crcbe_pkg::*;
(
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data_in,
  input wire logic reverse,
  output logic [15:0] crc_out
);

  // ==========================================================
  // one byte through the ccitt polynomial, msb first, or lsb first when reverse is set
  logic [7:0] din;
  logic [15:0] c;

  always_comb begin
    din = data_in;
    c = crc_in;
    if (reverse) begin
      for (int i = 0; i < 8; i++) begin
        din[i] = data_in[7-i];
      end
    end
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ din[i]) begin
        c = {c[14:0], 1'b0} ^ CRCBE_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule : crcbe_step

/* File: design/crcbe_engine.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - checksum uses the ccitt sixteen-bit polynomial 0x1021 on every byte
// - bytes enter one at a time; optional reversal of bit order per byte
// - updated sixteen-bit checksum held in result register after each byte
// - accumulator preset to all zeros or all ones before a calculation
// - hardware walks flash over one or more 256-byte blocks by itself
module crcbe_engine
  import crcbe_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic seed_load,
  input wire logic seed_ones,
  input wire logic reverse_en,
  input wire crcbe_byte_s sw_byte,
  output logic sw_ready,
  input wire logic walk_start,
  input wire logic [CRCBE_ADDR_W-1:0] walk_base,
  input wire logic [CRCBE_BLKCNT_W-1:0] walk_blocks,
  output logic flash_rd,
  output logic [CRCBE_ADDR_W-1:0] flash_addr,
  input wire logic [7:0] flash_data,
  output logic walk_busy,
  output logic walk_done,
  output logic [15:0] checksum_unit
);

  // ==========================================================
  // state
  crcbe_state_s st_r;
  crcbe_state_s st_nxt;
  logic [15:0] step_out;
  logic [7:0] feed;
  logic feed_en;

  // ==========================================================
  // decode
  function automatic logic is_idle(input crcbe_state_e s);
    return (s == CRCBE_IDLE);
  endfunction : is_idle

  // software bytes accepted only while no walk is in progress
  assign sw_ready = is_idle(st_r.state);
  assign walk_busy = !is_idle(st_r.state);
  assign walk_done = st_r.done;
  assign checksum_unit = st_r.result;
  assign flash_rd = (st_r.state == CRCBE_WALK);
  assign flash_addr = st_r.addr;

  always_comb begin
    feed_en = 1'b0;
    feed = sw_byte.data;
    if (st_r.rd_pend) begin
      feed_en = 1'b1;
      feed = flash_data;
    end else if (sw_ready && sw_byte.valid && !seed_load) begin
      feed_en = 1'b1;
    end
  end

  crcbe_step u_step (
    .crc_in(st_r.result),
    .data_in(feed),
    .reverse(st_r.reverse),
    .crc_out(step_out)
  );

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.rd_pend = 1'b0;
    st_nxt.last_pend = 1'b0;
    if (is_idle(st_r.state)) begin
      st_nxt.reverse = reverse_en;
    end
    if (feed_en) begin
      st_nxt.result = step_out;
    end
    case (st_r.state)
      CRCBE_IDLE: begin
        if (seed_load) begin
          st_nxt.result = seed_ones ? CRCBE_SEED_ONES : CRCBE_SEED_ZERO;
        end else if (walk_start && walk_blocks != '0) begin
          st_nxt.state = CRCBE_WALK;
          st_nxt.addr = walk_base;
          st_nxt.blocks_left = walk_blocks;
        end
      end
      CRCBE_WALK: begin
        st_nxt.rd_pend = 1'b1;
        st_nxt.addr = st_r.addr + 16'h0001;
        if (st_r.addr[7:0] == (walk_base[7:0] + CRCBE_LAST_IN_BLOCK)) begin
          st_nxt.blocks_left = st_r.blocks_left - 8'h01;
          if (st_r.blocks_left == 8'h01) begin
            st_nxt.state = CRCBE_DRAIN;
            // marks the final flash byte still in flight
            st_nxt.last_pend = 1'b1;
          end
        end
      end
      CRCBE_DRAIN: begin
        if (!st_r.rd_pend) begin
          st_nxt.state = CRCBE_IDLE;
          st_nxt.done = 1'b1;
        end
      end
      default: begin
        st_nxt.state = CRCBE_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r.state <= CRCBE_IDLE;
      st_r.result <= CRCBE_RST_RESULT;
      st_r.addr <= '0;
      st_r.blocks_left <= '0;
      st_r.rd_pend <= 1'b0;
      st_r.last_pend <= 1'b0;
      st_r.done <= 1'b0;
      st_r.reverse <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // checks
  // walk_cyc spans the whole walk, blk_cyc restarts at each block end
  int unsigned walk_cyc;
  int unsigned blk_cyc;
  always_ff @(posedge mclk) begin
    if (sys_rst || !walk_busy) begin
      walk_cyc <= 0;
      blk_cyc <= 0;
    end else if (clk_en) begin
      walk_cyc <= walk_cyc + 1;
      if (st_nxt.blocks_left != st_r.blocks_left) begin
        blk_cyc <= 0;
      end else begin
        blk_cyc <= blk_cyc + 1;
      end
    end
  end

  sequence seed_req_s;
    sw_ready && seed_load && clk_en;
  endsequence

  // ==========================================================
  // walk steps
  sequence fold_s;
    st_r.rd_pend && clk_en;
  endsequence

  sequence drain_end_s;
    (st_r.state == CRCBE_DRAIN) && !st_r.rd_pend && clk_en;
  endsequence

  sequence walk_step_s;
    flash_rd && clk_en;
  endsequence

  chk_seed_value: assert property (@(posedge mclk) disable iff (sys_rst)
    seed_req_s |=> checksum_unit == (($past(seed_ones)) ? CRCBE_SEED_ONES : CRCBE_SEED_ZERO))
    else $error("seed not loaded");

  chk_sw_update: assert property (@(posedge mclk) disable iff (sys_rst)
    (feed_en && clk_en && !st_r.rd_pend) |=> checksum_unit == $past(step_out))
    else $error("software byte not folded in");

  chk_hold_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    (!feed_en && !(sw_ready && seed_load)) |=> $stable(checksum_unit))
    else $error("result changed without byte");

  chk_walk_rate: assert property (@(posedge mclk) disable iff (sys_rst)
    (flash_rd && clk_en) |=> st_r.rd_pend)
    else $error("flash byte not consumed next cycle");

  chk_walk_bound: assert property (@(posedge mclk) disable iff (sys_rst)
    walk_cyc <= CRCBE_BLOCK_CYCLES_MAX * 256)
    else $error("walk ran too long");

  chk_addr_step: assert property (@(posedge mclk) disable iff (sys_rst)
    (flash_rd && $past(flash_rd) && $past(clk_en)) |-> flash_addr == $past(flash_addr) + 16'h0001)
    else $error("flash address did not step");

  chk_walk_start: assert property (@(posedge mclk) disable iff (sys_rst)
    (sw_ready && clk_en && !seed_load && walk_start && walk_blocks != '0)
      |=> flash_rd && flash_addr == $past(walk_base))
    else $error("walk did not start at base");

  chk_done_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    walk_done |-> !walk_busy && !($past(walk_done) && $past(clk_en)))
    else $error("done not a single pulse");

  chk_flash_fold: assert property (@(posedge mclk) disable iff (sys_rst)
    fold_s |=> checksum_unit == $past(step_out))
    else $error("flash byte not folded in");

  chk_drain_done: assert property (@(posedge mclk) disable iff (sys_rst)
    drain_end_s |=> walk_done && sw_ready)
    else $error("walk end not flagged");

  chk_last_byte: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r.last_pend |-> st_r.rd_pend && (st_r.state == CRCBE_DRAIN))
    else $error("last byte not in flight at drain");

  chk_block_time: assert property (@(posedge mclk) disable iff (sys_rst)
    walk_busy |-> blk_cyc < CRCBE_BLOCK_CYCLES_MAX)
    else $error("block took too long");

  chk_rev_frozen: assert property (@(posedge mclk) disable iff (sys_rst)
    walk_step_s |=> $stable(st_r.reverse))
    else $error("bit order changed during walk");

endmodule : crcbe_engine

/* File: bench/crcbe_flash_model.sv */
`timescale 1ns/1ps
module crcbe_flash_model
  import crcbe_pkg::*;
(
  input wire logic mclk,
  input wire logic clk_en,
  input wire logic flash_rd,
  input wire logic [CRCBE_ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_data
);
  // one cycle read latency; unread cycles show a changing pattern
  always_ff @(posedge mclk) begin
    if (clk_en) begin
      flash_data <= flash_rd ? flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h5a : ~flash_data;
    end
  end
endmodule : crcbe_flash_model

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import crcbe_pkg::*;
  logic mclk, sys_rst, clk_en, seed_load, seed_ones, reverse_en, walk_start;
  logic sw_ready, flash_rd, walk_busy, walk_done;
  crcbe_byte_s sw_byte;
  logic [15:0] walk_base, flash_addr, checksum_unit, model;
  logic [7:0] walk_blocks, flash_data;
  int err_count, num_checks;

  crcbe_engine i_dut (.mclk, .sys_rst, .clk_en, .seed_load, .seed_ones, .reverse_en,
    .sw_byte, .sw_ready, .walk_start, .walk_base, .walk_blocks, .flash_rd,
    .flash_addr, .flash_data, .walk_busy, .walk_done, .checksum_unit);
  crcbe_flash_model i_flash (.mclk, .clk_en, .flash_rd, .flash_addr, .flash_data);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================================
  // reference and checking
  function automatic logic [15:0] step(logic [15:0] c, logic [7:0] d, logic rev);
    logic b;
    for (int i = 0; i < 8; i++) begin
      b = (rev ? d[i] : d[7-i]) ^ c[15];
      c = {c[14:0], 1'b0} ^ (b ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : step

  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic seed(logic ones);
    seed_ones = ones;
    seed_load = 1'b1;
    @(negedge mclk);
    seed_load = 1'b0;
    model = ones ? 16'hffff : 16'h0000;
    chk("seed", checksum_unit, model);
  endtask : seed

  // ==========================================================
  // scenarios
  task automatic t_sw;
    for (int s = 0; s < 4; s++) begin
      reverse_en = s[1];
      seed(s[0]);
      foreach (walk_blocks[i]) begin
        sw_byte = {1'b1, 8'h01 << i};
        @(negedge mclk);
        model = step(model, sw_byte.data, s[1]);
        chk("sw_crc", checksum_unit, model);
      end
    end
    clk_en = 1'b0;
    sw_byte.data = 8'ha5;
    @(negedge mclk);
    sw_byte.valid = 1'b0;
    clk_en = 1'b1;
    chk("frozen", checksum_unit, model);
    walk_start = 1'b1;
    @(negedge mclk);
    walk_start = 1'b0;
    chk("no_walk", {walk_busy, flash_rd, sw_ready}, 16'h0001);
  endtask : t_sw

  task automatic t_walk(logic [7:0] nb, logic rev);
    int n, k;
    reverse_en = rev;
    seed(1'b1);
    walk_base = 16'h12f4;
    walk_blocks = nb;
    walk_start = 1'b1;
    @(negedge mclk);
    walk_start = 1'b0;
    k = 0;
    for (n = 0; n < 600 && walk_done !== 1'b1; n++) begin
      sw_byte.valid = (n == 5);
      if (n == 5) begin
        chk("refused", {walk_busy, sw_ready}, 16'h0002);
      end
      if (flash_rd === 1'b1) begin
        chk("addr", flash_addr, walk_base + 16'(k));
        model = step(model, flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h5a, rev);
        k++;
      end
      @(negedge mclk);
    end
    chk("reads", 16'(k), {nb, 8'h00});
    chk("late", 16'(n > CRCBE_BLOCK_CYCLES_MAX * nb), 16'h0000);
    chk("walk_crc", checksum_unit, model);
    @(negedge mclk);
    chk("done", {walk_busy, walk_done, sw_ready}, 16'h0001);
  endtask : t_walk

  initial begin
    {err_count, num_checks} = '0;
    {sys_rst, clk_en} = 2'b11;
    {seed_load, seed_ones, reverse_en, walk_start} = '0;
    sw_byte = '0;
    walk_base = '0;
    walk_blocks = '0;
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    chk("rst", checksum_unit, 16'h0000);
    chk("rst_flags", {walk_busy, walk_done, flash_rd, sw_ready}, 16'h0001);
    t_sw;
    t_walk(8'h01, 1'b0);
    t_walk(8'h02, 1'b1);
    results;
  end

  initial begin
    repeat (3000) @(posedge mclk);
    err_count++;
    results;
  end
endmodule : tb
